// ==== logic/pwp_top.sv ====
// Behaviour
// - Output frequency is 9.84 MHz over eight times period plus one.
// - Larger period value gives a slower output waveform.
// - Period 614 gives about 2 kHz, period 61439 about 20 Hz.
// - Period value is 16 bits, at most ffff, so nothing below about 18.8 Hz.
// - Separate duty value sets high/low ratio; 200 suits every frequency.
// - Pulse-train mode uses its own period value with the same relation.
// - Counter channel one is unavailable while either fast output runs.
// - Each counter has two inputs; unused strobe input stays a discrete input.
// - Enabled counter reports pulses seen per configured timebase.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "pwp_regs.svh"

module pwp_top #(
    parameter int N_CH      = 4,
    parameter int MS_CYCLES = `PWP_MS_PERIOD_NS / `PWP_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // Counter pins
    input  wire logic [N_CH-1:0] cnt_pin_i,
    input  wire logic [N_CH-1:0] aux_pin_i,
    // Fast output
    output logic                 pulse_out_o
);

    generate
        if (N_CH < 1 || N_CH > 4) begin : g_bad
            $error("N_CH must be 1 to 4");
        end
    endgenerate

    pwp_pkg::pwp_ctrl_s ctrl_r;
    pwp_pkg::pwp_wave_s wave_r;
    pwp_pkg::pwp_mode_e mode;
    pwp_pkg::pwp_mode_e mode_r;

    logic [15:0]      pwm_period_r;
    logic [15:0]      pwm_duty_r;
    logic [15:0]      pt_period_r;
    logic [15:0]      timebase_r;
    logic [N_CH-1:0]  cnt_s1_r;
    logic [N_CH-1:0]  cnt_s2_r;
    logic [N_CH-1:0]  aux_s1_r;
    logic [N_CH-1:0]  aux_s2_r;
    logic [N_CH-1:0]  ch_en;
    logic [15:0]      rate   [N_CH];
    logic [15:0]      strobe [N_CH];
    logic [15:0]      cnt_r;
    logic [32:0]      scaled_r;
    logic [32:0]      hi_lim_r;
    logic [31:0]      rd_mux;
    logic [15:0]      ctrl_merged;
    logic [N_CH-1:0]  disc;
    logic             out_active;
    logic             wr_en;
    logic             wrap;
    logic             reload;
    logic             base_tick;
    logic             ms_tick;
    logic             level_nxt;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    function automatic logic [16:0] half_of(input logic [15:0] per);
        return ({1'b0, per} + 17'h1) >> 1;
    endfunction

    pwp_tick_gen #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .base_tick_o (base_tick),
        .ms_tick_o   (ms_tick)
    );

    // Two-stage synchronisers for all pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_s1_r <= '0;
            cnt_s2_r <= '0;
            aux_s1_r <= '0;
            aux_s2_r <= '0;
        end else begin
            cnt_s1_r <= cnt_pin_i;
            cnt_s2_r <= cnt_s1_r;
            aux_s1_r <= aux_pin_i;
            aux_s2_r <= aux_s1_r;
        end
    end

    // output only in configured type A setup
    assign out_active = ctrl_r.type_a && !ctrl_r.cnt_en[0] && (ctrl_r.pwm_en || ctrl_r.pt_en);

    always_comb begin
        if (!out_active) begin
            mode = pwp_pkg::PWP_OFF;
        end else if (ctrl_r.pwm_en) begin
            mode = pwp_pkg::PWP_PWM;
        end else begin
            mode = pwp_pkg::PWP_PT;
        end
    end

    always_comb begin
        ch_en = ctrl_r.cnt_en[N_CH-1:0];
        if (out_active) begin
            ch_en[0] = 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            pwp_rate_cnt u_rate (
                .clk_i        (clk_i),
                .rst_i        (rst_i),
                .ms_tick_i    (ms_tick),
                .timebase_i   (timebase_r),
                .en_i         (ch_en[g]),
                .strobe_en_i  (ctrl_r.strobe_en[g]),
                .cnt_in_i     (cnt_s2_r[g]),
                .strobe_in_i  (aux_s2_r[g]),
                .rate_o       (rate[g]),
                .strobe_val_o (strobe[g])
            );
        end
    endgenerate

    // second input readable when not a strobe
    assign disc = aux_s2_r & ~ctrl_r.strobe_en[N_CH-1:0];

    // Wishbone: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // Control is 11 bits; merge on a 16-bit image and keep the low part
    assign ctrl_merged = merge16({5'h0, ctrl_r}, wb_dat_i, wb_sel_i);

    // period registers are 16 bits wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r       <= `PWP_RST_CTRL;
            pwm_period_r <= `PWP_RST_PERIOD;
            pwm_duty_r   <= `PWP_RST_DUTY;
            pt_period_r  <= `PWP_RST_PERIOD;
            timebase_r   <= `PWP_RST_TIMEBASE;
        end else if (wr_en) begin
            case (wb_adr_i)
                `PWP_OFF_CTRL: begin
                    ctrl_r <= pwp_pkg::pwp_ctrl_s'(ctrl_merged[10:0]);
                end
                `PWP_OFF_PWM_PERIOD: begin
                    pwm_period_r <= merge16(pwm_period_r, wb_dat_i, wb_sel_i);
                end
                `PWP_OFF_PWM_DUTY: begin
                    pwm_duty_r <= merge16(pwm_duty_r, wb_dat_i, wb_sel_i);
                end
                `PWP_OFF_PT_PERIOD: begin
                    pt_period_r <= merge16(pt_period_r, wb_dat_i, wb_sel_i);
                end
                `PWP_OFF_TIMEBASE: begin
                    timebase_r <= merge16(timebase_r, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    // Unmapped addresses read as zero and writes to them are dropped
    always_comb begin
        rd_mux = 32'h0;
        case (wb_adr_i)
            `PWP_OFF_CTRL:       rd_mux = {21'h0, ctrl_r};
            `PWP_OFF_PWM_PERIOD: rd_mux = {16'h0, pwm_period_r};
            `PWP_OFF_PWM_DUTY:   rd_mux = {16'h0, pwm_duty_r};
            `PWP_OFF_PT_PERIOD:  rd_mux = {16'h0, pt_period_r};
            `PWP_OFF_TIMEBASE:   rd_mux = {16'h0, timebase_r};
            `PWP_OFF_STATUS: begin
                rd_mux[`PWP_ST_ACTIVE] = out_active;
                rd_mux[`PWP_ST_LEVEL]  = pulse_out_o;
                rd_mux[`PWP_ST_DISC_LSB +: N_CH] = disc;
            end
            default: begin
                for (int i = 0; i < N_CH; i++) begin
                    if (wb_adr_i == `PWP_OFF_RATE_BASE + 8'(i) * `PWP_CH_STRIDE) begin
                        rd_mux = {16'h0, rate[i]};
                    end
                    if (wb_adr_i == `PWP_OFF_STROBE_BASE + 8'(i) * `PWP_CH_STRIDE) begin
                        rd_mux = {16'h0, strobe[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= rd_mux;
        end
    end

    // settings change only at the boundary
    assign wrap   = base_tick && (cnt_r == wave_r.period);
    assign reload = wrap || (mode_r == pwp_pkg::PWP_OFF) || (mode != mode_r);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r   <= pwp_pkg::PWP_OFF;
            wave_r   <= '0;
            hi_lim_r <= '0;
        end else begin
            mode_r <= mode;
            if (reload) begin
                // pulse train takes its own period
                wave_r.period <= (mode == pwp_pkg::PWP_PT) ? pt_period_r : pwm_period_r;
                wave_r.duty   <= pwm_duty_r;
                wave_r.half   <= half_of(pt_period_r);
                hi_lim_r      <= 33'(({1'b0, pwm_period_r} + 17'h1) * pwm_duty_r);
            end
        end
    end

    // one step per base/8 tick, period+1 steps per cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || reload) begin
            cnt_r    <= '0;
            scaled_r <= '0;
        end else if (base_tick) begin
            cnt_r    <= cnt_r + 16'h1;
            scaled_r <= scaled_r + 33'(`PWP_DUTY_FULL);
        end
    end

    // high fraction is duty over 400; 200 gives half
    always_comb begin
        case (mode_r)
            pwp_pkg::PWP_PWM: level_nxt = scaled_r < hi_lim_r;
            pwp_pkg::PWP_PT:  level_nxt = {1'b0, cnt_r} < wave_r.half;
            default:          level_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_out_o <= 1'b0;
        end else begin
            pulse_out_o <= level_nxt;
        end
    end

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    a_wrap_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> cnt_r == 16'h0 && scaled_r == 33'h0) else $error("no restart at wrap");
    a_cnt_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r != pwp_pkg::PWP_OFF && !$past(reload) |-> cnt_r <= wave_r.period)
        else $error("counter past period");
    a_off_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !out_active ##1 !out_active |=> !pulse_out_o) else $error("output while off");
    a_ch0_block: assert property (@(posedge clk_i) disable iff (rst_i)
        out_active |-> !ch_en[0]) else $error("channel one counting with output");
    a_pt_high: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r == pwp_pkg::PWP_PT && {1'b0, cnt_r} < wave_r.half |=> pulse_out_o)
        else $error("pulse train low in first half");
    a_duty_full: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r == pwp_pkg::PWP_PWM && wave_r.duty >= 16'(`PWP_DUTY_FULL) |=> pulse_out_o)
        else $error("full duty not high");

endmodule

// ==== logic/pwp_regs.svh ====
`ifndef PWP_REGS_SVH
`define PWP_REGS_SVH

// Register byte offsets
`define PWP_OFF_CTRL        8'h00
`define PWP_OFF_PWM_PERIOD  8'h04
`define PWP_OFF_PWM_DUTY    8'h08
`define PWP_OFF_PT_PERIOD   8'h0c
`define PWP_OFF_TIMEBASE    8'h10
`define PWP_OFF_STATUS      8'h14
`define PWP_OFF_RATE_BASE   8'h20
`define PWP_OFF_STROBE_BASE 8'h30
`define PWP_CH_STRIDE       8'h04

// Status field positions
`define PWP_ST_ACTIVE       0
`define PWP_ST_LEVEL        1
`define PWP_ST_DISC_LSB     4

// Reset values
`define PWP_RST_CTRL        11'h000
`define PWP_RST_PERIOD      16'hffff
`define PWP_RST_DUTY        16'h00c8
`define PWP_RST_TIMEBASE    16'h03e8

// Timing
`define PWP_BASE_KHZ        9840
`define PWP_BASE_DIV        8
`define PWP_CLK_KHZ         25000
`define PWP_CLK_PERIOD_NS   40
`define PWP_MS_PERIOD_NS    1000000
`define PWP_DUTY_FULL       400

`endif

// ==== logic/pwp_pkg.sv ====
package pwp_pkg;

    typedef enum logic [1:0] {
        PWP_OFF,
        PWP_PWM,
        PWP_PT
    } pwp_mode_e;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [3:0] strobe_en;
        logic [3:0] cnt_en;
        logic       type_a;
        logic       pt_en;
        logic       pwm_en;
    } pwp_ctrl_s;

    // Waveform settings latched at a period boundary
    typedef struct packed {
        logic [15:0] period;
        logic [15:0] duty;
        logic [16:0] half;
    } pwp_wave_s;

endpackage

// ==== logic/pwp_tick_gen.sv ====
`timescale 1ns/1ns
`include "pwp_regs.svh"

module pwp_tick_gen #(
    parameter int MS_CYCLES = `PWP_MS_PERIOD_NS / `PWP_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Enables
    output logic      base_tick_o,
    output logic      ms_tick_o
);

    localparam logic [14:0] STEP = 15'(`PWP_BASE_KHZ / `PWP_BASE_DIV);
    localparam logic [14:0] MODV = 15'(`PWP_CLK_KHZ);

    logic [14:0] acc_r;
    logic [15:0] acc_sum;
    logic [31:0] ms_cnt_r;

    generate
        if (MS_CYCLES < 1) begin : g_bad
            $error("MS_CYCLES must be at least 1");
        end
    endgenerate

    // Phase accumulator: average rate is exactly base/8 from the 25 MHz clock
    assign acc_sum = {1'b0, acc_r} + {1'b0, STEP};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r       <= '0;
            base_tick_o <= 1'b0;
        end else if (acc_sum >= {1'b0, MODV}) begin
            acc_r       <= 15'(acc_sum - {1'b0, MODV});
            base_tick_o <= 1'b1;
        end else begin
            acc_r       <= acc_sum[14:0];
            base_tick_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_r  <= '0;
            ms_tick_o <= 1'b0;
        end else if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
            ms_cnt_r  <= '0;
            ms_tick_o <= 1'b1;
        end else begin
            ms_cnt_r  <= ms_cnt_r + 32'h1;
            ms_tick_o <= 1'b0;
        end
    end

endmodule

// ==== logic/pwp_rate_cnt.sv ====
`timescale 1ns/1ns

module pwp_rate_cnt (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Timebase
    input  wire logic        ms_tick_i,
    input  wire logic [15:0] timebase_i,
    // Control
    input  wire logic        en_i,
    input  wire logic        strobe_en_i,
    // Synchronised pins
    input  wire logic        cnt_in_i,
    input  wire logic        strobe_in_i,
    // Results
    output logic [15:0]      rate_o,
    output logic [15:0]      strobe_val_o
);

    logic        cnt_d_r;
    logic        stb_d_r;
    logic [15:0] acc_r;
    logic [15:0] ms_r;
    logic        rise;
    logic        window_end;

    assign rise       = cnt_in_i & ~cnt_d_r;
    assign window_end = ms_tick_i && (ms_r + 16'h1 >= timebase_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_d_r <= 1'b0;
            stb_d_r <= 1'b0;
        end else begin
            cnt_d_r <= cnt_in_i;
            stb_d_r <= strobe_in_i;
        end
    end

    // Pulses per timebase; saturates so a too long window never wraps
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            acc_r  <= '0;
            ms_r   <= '0;
            rate_o <= '0;
        end else if (window_end) begin
            rate_o <= (rise && acc_r != 16'hffff) ? acc_r + 16'h1 : acc_r;
            acc_r  <= '0;
            ms_r   <= '0;
        end else begin
            if (ms_tick_i) begin
                ms_r <= ms_r + 16'h1;
            end
            if (rise && acc_r != 16'hffff) begin
                acc_r <= acc_r + 16'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_val_o <= '0;
        end else if (en_i && strobe_en_i && strobe_in_i && !stb_d_r) begin
            strobe_val_o <= acc_r;
        end
    end

    a_rate_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_i |=> rate_o == 16'h0) else $error("rate not cleared when off");

endmodule

// ==== verif/pwp_cond_model.sv ====
`timescale 1ns/1ns
// Conditioner stand-in: feeds a square wave to the counter pins and times the fast output
module pwp_cond_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wave source, half period in clocks; zero parks the line low like an idle unit
    input  wire logic [15:0] half_i,
    output logic             wave_o,
    // Fast output seen at the far side
    input  wire logic        pulse_i,
    output logic [31:0]      period_o,
    output logic [31:0]      high_o,
    output logic [15:0]      rises_o
);
    logic [15:0] div_r;
    logic [31:0] age_r;
    logic        prev_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || half_i == 16'h0000) begin
            div_r  <= 16'h0000;
            wave_o <= 1'b0;
        end else if (div_r + 16'h0001 >= half_i) begin
            div_r  <= 16'h0000;
            wave_o <= ~wave_o;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // Periods are timed rise to rise, high time rise to fall
    always_ff @(posedge clk_i) begin
        prev_r <= pulse_i;
        if (rst_i) begin
            age_r    <= 32'h0;
            period_o <= 32'h0;
            high_o   <= 32'h0;
            rises_o  <= 16'h0;
        end else if (pulse_i && !prev_r) begin
            period_o <= age_r + 32'h1;
            age_r    <= 32'h0;
            rises_o  <= rises_o + 16'h1;
        end else begin
            age_r <= age_r + 32'h1;
            if (!pulse_i && prev_r) begin
                high_o <= age_r + 32'h1;
            end
        end
    end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`include "pwp_regs.svh"
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_r = 1'b1;
    logic        cyc_r = 1'b0;
    logic        stb_r = 1'b0;
    logic        we_r = 1'b0;
    logic [7:0]  adr_r = 8'h00;
    logic [31:0] dat_r = 32'h0;
    logic [3:0]  aux_r = 4'h0;
    logic [3:0]  sel_r = 4'h0;
    logic [15:0] half_r = 16'h0;
    logic [31:0] wb_dat_o, period, high, q;
    logic [15:0] rises;
    logic        ack, pulse, wave;
    int          mismatches = 0;
    int          n_compared = 0;

    always #20 clk_i = ~clk_i;

    pwp_top #(.N_CH(4), .MS_CYCLES(10)) dut (.clk_i(clk_i), .rst_i(rst_r), .wb_cyc_i(cyc_r),
        .wb_stb_i(stb_r), .wb_we_i(we_r), .wb_adr_i(adr_r), .wb_sel_i(sel_r),
        .wb_dat_i(dat_r), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .cnt_pin_i({4{wave}}),
        .aux_pin_i(aux_r), .pulse_out_o(pulse));
    pwp_cond_model u_cond (.clk_i(clk_i), .rst_i(rst_r), .half_i(half_r), .wave_o(wave),
        .pulse_i(pulse), .period_o(period), .high_o(high), .rises_o(rises));

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_in(input string what, input int lo, input int hi, input logic [31:0] got);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Classic single cycle; ack is read as sampled at the edge, before its own update lands
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_r <= 1'b1;
        stb_r <= 1'b1;
        we_r  <= we;
        sel_r <= 4'hf;
        adr_r <= a;
        dat_r <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc_r <= 1'b0;
        stb_r <= 1'b0;
        if (ack !== 1'b1) begin
            $display("[ERR] wishbone ack expected 1 seen timeout");
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask

    function automatic logic [31:0] mk_ctrl(input logic [3:0] ce, input logic ta,
                                            input logic pt, input logic pw);
        pwp_pkg::pwp_ctrl_s c;
        c = '{strobe_en: 4'b0001, cnt_en: ce, type_a: ta, pt_en: pt, pwm_en: pw};
        return {21'h000000, c};
    endfunction

    task automatic wait_rises(input int k);
        logic [15:0] s;
        int          n;
        s = rises;
        n = 0;
        while (rises !== s + 16'(k) && n < 30000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 30000) begin
            $display("[ERR] output edges expected %0d seen timeout", k);
            mismatches++;
            wrap_up();
        end
    endtask

    // Clocks per output period and per high time, from the base tick of 9.84 MHz / 8
    function automatic int clks(input int ticks);
        return (ticks * `PWP_CLK_KHZ * `PWP_BASE_DIV) / `PWP_BASE_KHZ;
    endfunction

    task automatic measure(input string what, input int p, input int hticks);
        // Third rise: both timed spans follow a setting written before the call
        wait_rises(3);
        chk_in({what, " period"}, clks(p + 1) - 3, clks(p + 1) + 3, period);
        chk_in({what, " high"}, clks(hticks) - 3, clks(hticks) + 3, high);
    endtask

    task automatic t_regs();
        rd_chk("ctrl", `PWP_OFF_CTRL, 32'h0);
        rd_chk("pwm period", `PWP_OFF_PWM_PERIOD, 32'hffff);
        rd_chk("pwm duty", `PWP_OFF_PWM_DUTY, 32'h00c8);
        rd_chk("pt period", `PWP_OFF_PT_PERIOD, 32'hffff);
        rd_chk("timebase", `PWP_OFF_TIMEBASE, 32'h03e8);
        wb_xfer(1'b1, 8'h18, 32'h5a5a);
        rd_chk("unmapped", 8'h18, 32'h0);
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'hdead_beef);
        rd_chk("period width", `PWP_OFF_PWM_PERIOD, 32'h0000_beef);
        $display("test regs done");
    endtask

    task automatic t_count();
        wb_xfer(1'b1, `PWP_OFF_TIMEBASE, 32'd20);
        wb_xfer(1'b1, `PWP_OFF_CTRL, mk_ctrl(4'b0110, 1'b1, 1'b0, 1'b0));
        aux_r  <= 4'b1011;
        half_r <= 16'd10;
        repeat (700) @(posedge clk_i);
        // 20 clock wave over a 200 clock window gives ten pulses
        rd_chk("rate ch1", `PWP_OFF_RATE_BASE + 8'h04, 32'd10);
        rd_chk("rate ch2", `PWP_OFF_RATE_BASE + 8'h08, 32'd10);
        rd_chk("rate ch3 off", `PWP_OFF_RATE_BASE + 8'h0c, 32'd0);
        wb_xfer(1'b0, `PWP_OFF_STATUS, 32'h0);
        chk("discrete inputs", 32'ha, {28'h0, q[7:4]});
        $display("test count done");
    endtask

    task automatic t_enable();
        logic [31:0] cfg [4];
        int          h;
        cfg = '{mk_ctrl(4'b0, 1'b0, 1'b0, 1'b1), mk_ctrl(4'b1, 1'b1, 1'b0, 1'b1),
                mk_ctrl(4'b1, 1'b1, 1'b1, 1'b0), mk_ctrl(4'b0, 1'b1, 1'b0, 1'b1)};
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd9);
        for (int i = 0; i < 4; i++) begin
            wb_xfer(1'b1, `PWP_OFF_CTRL, cfg[i]);
            h = 0;
            repeat (450) begin
                @(posedge clk_i);
                h += (pulse === 1'b1);
            end
            wb_xfer(1'b0, `PWP_OFF_STATUS, 32'h0);
            chk("output active", 32'(i == 3), {31'h0, q[0]});
            chk("output toggled", 32'(i == 3), 32'(h > 0));
            if (i == 1) rd_chk("rate ch0 counting", `PWP_OFF_RATE_BASE, 32'd10);
        end
        rd_chk("rate ch0 shared", `PWP_OFF_RATE_BASE, 32'd0);
        $display("test enable done");
    endtask

    task automatic t_freq();
        int h;
        measure("p9 d200", 9, 5);
        wb_xfer(1'b1, `PWP_OFF_PWM_DUTY, 32'd100);
        measure("p9 d100", 9, 3);
        wb_xfer(1'b1, `PWP_OFF_PWM_DUTY, 32'd200);
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd19);
        measure("p19", 19, 10);
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd614);
        measure("p614", 614, 308);
        wb_xfer(1'b1, `PWP_OFF_PWM_DUTY, 32'd400);
        // Full duty lands at the next boundary, which opens with a rise
        wait_rises(1);
        h = 0;
        repeat (13000) begin
            @(posedge clk_i);
            h += (pulse !== 1'b1);
        end
        chk("full duty low clocks", 32'h0, 32'(h));
        $display("test freq done");
    endtask

    task automatic t_bound();
        wb_xfer(1'b1, `PWP_OFF_PWM_DUTY, 32'd200);
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd9);
        wait_rises(3);
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd19);
        wait_rises(1);
        chk_in("old period kept", clks(10) - 3, clks(10) + 3, period);
        wait_rises(1);
        chk_in("new period", clks(20) - 3, clks(20) + 3, period);
        $display("test boundary done");
    endtask

    task automatic t_pt();
        wb_xfer(1'b1, `PWP_OFF_PWM_PERIOD, 32'd9);
        wb_xfer(1'b1, `PWP_OFF_PT_PERIOD, 32'd19);
        wb_xfer(1'b1, `PWP_OFF_CTRL, mk_ctrl(4'b0, 1'b1, 1'b1, 1'b0));
        measure("pulse train", 19, 10);
        $display("test pulse train done");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_r <= 1'b0;
        t_regs();
        t_count();
        t_enable();
        t_freq();
        t_bound();
        t_pt();
        wrap_up();
    end
endmodule
